// ==== src/cstc_cfg.svh ====
/*
  constants for the chassis status and timing controller: register offsets,
  field positions, reset values and timing counts.
  assumes a 100 MHz core clock.
*/
`ifndef CSTC_CFG_SVH
`define CSTC_CFG_SVH

`define CSTC_CLK_MHZ          100
`define CSTC_BLINK_HALF_MS    250
`define CSTC_BLINK_HALF_CYC   (`CSTC_BLINK_HALF_MS * 1000 * `CSTC_CLK_MHZ)
`define CSTC_SYNC_HALF_NS     50
`define CSTC_SYNC_HALF_CYC    (`CSTC_SYNC_HALF_NS * `CSTC_CLK_MHZ / 1000)
`define CSTC_OVERTEMP_C       8'h37
`define CSTC_FAN_FULL         8'h64
`define CSTC_FAN_MIN          8'h1E

`define CSTC_REG_CTRL         8'h00
`define CSTC_REG_BRIDGE_LO    8'h04
`define CSTC_REG_BRIDGE_HI    8'h08
`define CSTC_REG_STATUS       8'h0C
`define CSTC_REG_FAN          8'h10

`define CSTC_CTRL_SYNCDIV     0
`define CSTC_CTRL_RESET       8'h00
`define CSTC_BRIDGE_RESET     16'h0000

`endif

// ==== src/cstc_pkg.sv ====
/*
  types for the chassis status and timing controller.
  assumes cstc_cfg.svh is available to the design.
*/
package cstc_pkg;
  typedef enum logic [1:0] {CSTC_BR_OFF, CSTC_BR_UP, CSTC_BR_DOWN, CSTC_BR_RSV} cstc_bridge_e;
  typedef enum {CSTC_PWR_OFF, CSTC_PWR_ON} cstc_pwr_e;
  typedef enum logic [1:0] {CSTC_REF_NONE, CSTC_REF_SLOT, CSTC_REF_EXT, CSTC_REF_INT} cstc_ref_e;
endpackage

// ==== src/cstc_top.sv ====
/*
  chassis status and timing controller: front lamps, fan level, power
  and inhibit sequencing, trigger bridges, reference selection, sync.
  assumes synchronous inputs, a 100 MHz clock, and a nonvolatile store
  outside that presents the saved bridge setup at reset release.
*/
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
`include "cstc_cfg.svh"

module cstc_top
  import cstc_pkg::*;
#(
  parameter int BLINK_HALF = `CSTC_BLINK_HALF_CYC,
  parameter int LINES      = 8
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [31:0]          reg_rdata,
  input  wire logic                 ac_present,
  input  wire logic                 power_button,
  input  wire logic                 auto_boot_position,
  input  wire logic                 inhibit_n,
  input  wire logic                 fan_max_switch,
  input  wire logic                 fan_failed,
  input  wire logic                 voltage_fault,
  input  wire logic [7:0]           intake_temp,
  input  wire logic [7:0]           sensor_temp,
  input  wire logic [2*LINES-1:0]   saved_bridge,
  output logic                      bridge_save,
  input  wire logic [LINES-1:0]     trig_in_seg1,
  input  wire logic [LINES-1:0]     trig_in_seg2,
  input  wire logic [LINES-1:0]     trig_in_seg3,
  output logic      [LINES-1:0]     trig_out_seg1,
  output logic      [LINES-1:0]     trig_out_seg2,
  output logic      [LINES-1:0]     trig_out_seg3,
  output logic      [LINES-1:0]     trig_oe_seg1,
  output logic      [LINES-1:0]     trig_oe_seg2,
  output logic      [LINES-1:0]     trig_oe_seg3,
  input  wire logic                 slot_ref_present,
  input  wire logic                 external_reference_input,
  input  wire logic                 sync_ctrl,
  output logic      [1:0]           ref_select,
  output logic                      sync_out,
  output logic                      power_on,
  output logic      [7:0]           fan_duty,
  output logic                      front_white_lamp_drive,
  output logic                      front_red_lamp_drive
);

  // ==========================================================================
  // registers
  logic [7:0]         ctrl_r;
  logic [2*LINES-1:0] bridge_r;
  logic               bridge_loaded_r;
  logic               button_q_r;
  cstc_pwr_e          pwr_r;
  logic [31:0]        blink_cnt_r;
  logic               blink_r;
  logic [7:0]         sync_cnt_r;
  logic               sync_phase_r;
  cstc_ref_e          ref_nxt;

  // ==========================================================================
  // register bus
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_r <= `CSTC_CTRL_RESET;
    end else if (reg_wr && reg_addr == `CSTC_REG_CTRL) begin
      ctrl_r <= reg_wdata[7:0];
    end
  end

  // bridge setup comes from the store once after reset, then from software
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bridge_r        <= `CSTC_BRIDGE_RESET;
      bridge_loaded_r <= 1'b0;
      bridge_save     <= 1'b0;
    end else begin
      bridge_save <= 1'b0;
      if (!bridge_loaded_r) begin
        bridge_r        <= saved_bridge;
        bridge_loaded_r <= 1'b1;
      end else if (reg_wr && reg_addr == `CSTC_REG_BRIDGE_LO) begin
        bridge_r    <= reg_wdata[2*LINES-1:0];
        bridge_save <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (!reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_addr == `CSTC_REG_CTRL) begin
      reg_rdata <= {24'h00_0000, ctrl_r};
    end else if (reg_addr == `CSTC_REG_BRIDGE_LO) begin
      reg_rdata <= {{(32-2*LINES){1'b0}}, bridge_r};
    end else if (reg_addr == `CSTC_REG_STATUS) begin
      reg_rdata <= {26'h000_0000, ref_select, fan_failed, voltage_fault,
                    auto_boot_position, power_on};
    end else if (reg_addr == `CSTC_REG_FAN) begin
      reg_rdata <= {24'h00_0000, fan_duty};
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ==========================================================================
  // power and inhibit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      button_q_r <= 1'b0;
      pwr_r      <= CSTC_PWR_OFF;
    end else begin
      button_q_r <= power_button;
      case (pwr_r)
        CSTC_PWR_OFF: begin
          if (ac_present && inhibit_n) begin
            if (auto_boot_position) begin
              pwr_r <= CSTC_PWR_ON;
            end else if (power_button && !button_q_r) begin
              pwr_r <= CSTC_PWR_ON;
            end
          end
        end
        CSTC_PWR_ON: begin
          if (!inhibit_n || !ac_present) begin
            pwr_r <= CSTC_PWR_OFF;
          end else if (!auto_boot_position && power_button && !button_q_r) begin
            pwr_r <= CSTC_PWR_OFF;
          end
        end
        default: pwr_r <= CSTC_PWR_OFF;
      endcase
    end
  end

  // inhibit acts on the output directly so shutdown needs no state step
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      power_on <= 1'b0;
    end else begin
      power_on <= (pwr_r == CSTC_PWR_ON) && inhibit_n && ac_present;
    end
  end

  // ==========================================================================
  // lamps
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      blink_cnt_r <= 32'h0000_0000;
      blink_r     <= 1'b0;
    end else if (blink_cnt_r >= 32'(BLINK_HALF - 1)) begin
      blink_cnt_r <= 32'h0000_0000;
      blink_r     <= ~blink_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      front_white_lamp_drive <= 1'b0;
      front_red_lamp_drive   <= 1'b0;
    end else if (!power_on) begin
      front_white_lamp_drive <= 1'b0;
      front_red_lamp_drive   <= 1'b0;
    end else if (voltage_fault) begin
      front_white_lamp_drive <= 1'b0;
      front_red_lamp_drive   <= blink_r;
    end else if (fan_failed) begin
      front_white_lamp_drive <= 1'b0;
      front_red_lamp_drive   <= 1'b1;
    end else if (intake_temp > `CSTC_OVERTEMP_C) begin
      front_white_lamp_drive <= blink_r;
      front_red_lamp_drive   <= 1'b0;
    end else begin
      front_white_lamp_drive <= 1'b1;
      front_red_lamp_drive   <= 1'b0;
    end
  end

  // ==========================================================================
  // fans: linear curve, clamp between minimum and full
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fan_duty <= `CSTC_FAN_FULL;
    end else if (fan_max_switch) begin
      fan_duty <= `CSTC_FAN_FULL;
    end else if (sensor_temp >= `CSTC_FAN_FULL) begin
      fan_duty <= `CSTC_FAN_FULL;
    end else if (sensor_temp < `CSTC_FAN_MIN) begin
      fan_duty <= `CSTC_FAN_MIN;
    end else begin
      fan_duty <= sensor_temp;
    end
  end

  // ==========================================================================
  // trigger bridges: bit pair per line, seg1<->seg2 and seg2<->seg3 share it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      trig_out_seg1 <= '0;
      trig_out_seg2 <= '0;
      trig_out_seg3 <= '0;
      trig_oe_seg1  <= '0;
      trig_oe_seg2  <= '0;
      trig_oe_seg3  <= '0;
    end else begin
      for (int i = 0; i < LINES; i++) begin
        case (cstc_bridge_e'(bridge_r[2*i +: 2]))
          CSTC_BR_UP: begin
            trig_out_seg1[i] <= 1'b0;
            trig_oe_seg1[i]  <= 1'b0;
            trig_out_seg2[i] <= trig_in_seg1[i];
            trig_oe_seg2[i]  <= 1'b1;
            trig_out_seg3[i] <= trig_in_seg2[i];
            trig_oe_seg3[i]  <= 1'b1;
          end
          CSTC_BR_DOWN: begin
            trig_out_seg1[i] <= trig_in_seg2[i];
            trig_oe_seg1[i]  <= 1'b1;
            trig_out_seg2[i] <= trig_in_seg3[i];
            trig_oe_seg2[i]  <= 1'b1;
            trig_out_seg3[i] <= 1'b0;
            trig_oe_seg3[i]  <= 1'b0;
          end
          default: begin
            trig_out_seg1[i] <= 1'b0;
            trig_oe_seg1[i]  <= 1'b0;
            trig_out_seg2[i] <= 1'b0;
            trig_oe_seg2[i]  <= 1'b0;
            trig_out_seg3[i] <= 1'b0;
            trig_oe_seg3[i]  <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // reference and sync
  always_comb begin
    if (slot_ref_present) begin
      ref_nxt = CSTC_REF_SLOT;
    end else if (external_reference_input) begin
      ref_nxt = CSTC_REF_EXT;
    end else begin
      ref_nxt = CSTC_REF_INT;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_cnt_r   <= 8'h00;
      sync_phase_r <= 1'b0;
    end else if (sync_cnt_r >= 8'(`CSTC_SYNC_HALF_CYC - 1)) begin
      sync_cnt_r   <= 8'h00;
      sync_phase_r <= ~sync_phase_r;
    end else begin
      sync_cnt_r <= sync_cnt_r + 8'h01;
    end
  end

  // switching only at the period boundary keeps every derived clock whole
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ref_select <= 2'(CSTC_REF_INT);
    end else if (sync_phase_r && sync_cnt_r == 8'(`CSTC_SYNC_HALF_CYC - 1)) begin
      ref_select <= 2'(ref_nxt);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_out <= 1'b0;
    end else if (ctrl_r[`CSTC_CTRL_SYNCDIV]) begin
      sync_out <= sync_phase_r;
    end else begin
      sync_out <= sync_phase_r && sync_ctrl;
    end
  end

  // ==========================================================================
  // checks
  a_inhibit_shutdown: assert property (@(posedge clk) disable iff (reset)
    !inhibit_n |=> !power_on) else $error("power stayed on under inhibit");
  a_off_dark: assert property (@(posedge clk) disable iff (reset)
    !power_on |=> !front_white_lamp_drive && !front_red_lamp_drive)
    else $error("lamp lit while off");
  a_fan_red: assert property (@(posedge clk) disable iff (reset)
    power_on && fan_failed && !voltage_fault |=> front_red_lamp_drive && !front_white_lamp_drive)
    else $error("fan failure not solid red");
  a_volt_white_low: assert property (@(posedge clk) disable iff (reset)
    power_on && voltage_fault |=> !front_white_lamp_drive)
    else $error("white lit on voltage fault");
  a_fan_max: assert property (@(posedge clk) disable iff (reset)
    fan_max_switch |=> fan_duty == `CSTC_FAN_FULL) else $error("max fan not full");
  a_ref_slot_wins: assert property (@(posedge clk) disable iff (reset)
    slot_ref_present [*1] ##1 slot_ref_present [*8] |-> ##[0:12] ref_select == 2'(CSTC_REF_SLOT))
    else $error("slot reference not taken");
  a_ref_stable: assert property (@(posedge clk) disable iff (reset)
    !(sync_phase_r && sync_cnt_r == 8'(`CSTC_SYNC_HALF_CYC - 1)) |=> $stable(ref_select))
    else $error("reference changed mid period");
  a_sync_gate: assert property (@(posedge clk) disable iff (reset)
    !ctrl_r[`CSTC_CTRL_SYNCDIV] && !sync_ctrl |=> !sync_out) else $error("sync not gated");
  a_sync_free: assert property (@(posedge clk) disable iff (reset)
    ctrl_r[`CSTC_CTRL_SYNCDIV] |=> sync_out == $past(sync_phase_r)) else $error("sync gated");
  a_bridge_off: assert property (@(posedge clk) disable iff (reset)
    bridge_r == '0 |=> trig_oe_seg1 == '0 && trig_oe_seg2 == '0 && trig_oe_seg3 == '0)
    else $error("bridge drives while disabled");
  a_on_white: assert property (@(posedge clk) disable iff (reset)
    power_on && !voltage_fault && !fan_failed && intake_temp <= `CSTC_OVERTEMP_C
    |=> front_white_lamp_drive && !front_red_lamp_drive) else $error("normal lamp wrong");
  a_hot_flash: assert property (@(posedge clk) disable iff (reset)
    power_on && !voltage_fault && !fan_failed && intake_temp > `CSTC_OVERTEMP_C
    |=> front_white_lamp_drive == $past(blink_r) && !front_red_lamp_drive)
    else $error("overtemperature lamp wrong");
  a_volt_flash: assert property (@(posedge clk) disable iff (reset)
    power_on && voltage_fault |=> front_red_lamp_drive == $past(blink_r))
    else $error("voltage fault not flashing red");
  a_fan_follow: assert property (@(posedge clk) disable iff (reset)
    !fan_max_switch && sensor_temp >= `CSTC_FAN_MIN && sensor_temp < `CSTC_FAN_FULL
    |=> fan_duty == $past(sensor_temp)) else $error("fan duty not following temperature");
  a_ref_ext_pick: assert property (@(posedge clk) disable iff (reset)
    sync_phase_r && sync_cnt_r == 8'(`CSTC_SYNC_HALF_CYC - 1) && !slot_ref_present
    && external_reference_input |=> ref_select == 2'(CSTC_REF_EXT))
    else $error("external reference not taken");
  a_ref_int_pick: assert property (@(posedge clk) disable iff (reset)
    sync_phase_r && sync_cnt_r == 8'(`CSTC_SYNC_HALF_CYC - 1) && !slot_ref_present
    && !external_reference_input |=> ref_select == 2'(CSTC_REF_INT))
    else $error("internal reference not taken");
  a_manual_boot: assert property (@(posedge clk) disable iff (reset)
    pwr_r == CSTC_PWR_OFF && auto_boot_position && ac_present && inhibit_n
    |=> pwr_r == CSTC_PWR_ON) else $error("manual mode did not boot");

  c_power_up: cover property (@(posedge clk) disable iff (reset) $rose(power_on));
  c_inhibit: cover property (@(posedge clk) disable iff (reset) power_on ##1 !inhibit_n);
  c_ref_ext: cover property (@(posedge clk) disable iff (reset)
    ref_select == 2'(CSTC_REF_EXT));
  c_bridge_up: cover property (@(posedge clk) disable iff (reset) bridge_save);
  c_volt_flash: cover property (@(posedge clk) disable iff (reset)
    power_on && voltage_fault);

endmodule // cstc_top

// ==== test/cstc_inhibit_chain.sv ====
/*
  inhibit chain model: one more chained chassis on the shared inhibit line.
  assumes the line has a pull-up, so a released line reads high.
*/
`timescale 1ns/1ps
// ==========================================================================
// model
module cstc_inhibit_chain (
  input  wire logic pull_low,
  output logic      inhibit_n
);
  // open drain with pull-up: a released line goes high, never holds a last value
  assign inhibit_n = pull_low ? 1'b0 : 1'b1;
endmodule // cstc_inhibit_chain

// ==== test/cstc_tb.sv ====
/*
  self-checking bench for the chassis status and timing controller.
  assumes the inhibit chain model, a 100 MHz clock and a short blink count.
*/
`timescale 1ns/1ps
`include "cstc_cfg.svh"
module chassis_status_timing_control_tb_top;
  logic        clk, reset, reg_wr, reg_rd, ac, btn, manual, pull_low;
  logic        fan_max, fan_fail, vfault, slot_ref, ext_ref, sync_ctrl;
  logic [7:0]  reg_addr, intake, sensor, tin1, tin2, tin3;
  logic [31:0] reg_wdata, d;
  logic [15:0] saved;
  wire  [31:0] rdata;
  wire  [7:0]  to1, to2, to3, oe1, oe2, oe3, duty;
  wire  [1:0]  refsel;
  wire         sync_out, power_on, white, red, bsave, inh_n;
  int          num_errors, n_tests;

  cstc_inhibit_chain chain (.pull_low(pull_low), .inhibit_n(inh_n));
  cstc_top #(.BLINK_HALF(4), .LINES(8)) dut (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .ac_present(ac),
    .power_button(btn), .auto_boot_position(manual), .inhibit_n(inh_n),
    .fan_max_switch(fan_max), .fan_failed(fan_fail), .voltage_fault(vfault),
    .intake_temp(intake), .sensor_temp(sensor), .saved_bridge(saved),
    .bridge_save(bsave), .trig_in_seg1(tin1), .trig_in_seg2(tin2),
    .trig_in_seg3(tin3), .trig_out_seg1(to1), .trig_out_seg2(to2),
    .trig_out_seg3(to3), .trig_oe_seg1(oe1), .trig_oe_seg2(oe2),
    .trig_oe_seg3(oe3), .slot_ref_present(slot_ref),
    .external_reference_input(ext_ref), .sync_ctrl(sync_ctrl),
    .ref_select(refsel), .sync_out(sync_out), .power_on(power_on),
    .fan_duty(duty), .front_white_lamp_drive(white), .front_red_lamp_drive(red));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================================================
  // shared tasks
  task close_out;
    if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  // kind 0 dark, 1 solid, 2 flashing; sel 0 white, 1 red, 2 sync
  task watch(input int sel, input int kind);
    logic v, p;
    int   i, highs, flips;
    highs = 0; flips = 0; p = 1'b0;
    // let a stimulus set on the last edge reach the registered output first
    @(posedge clk);
    for (i = 0; i < 20; i++) begin
      @(negedge clk);
      v = (sel == 0) ? white : (sel == 1) ? red : sync_out;
      if (v === 1'b1) highs++;
      if (i > 0 && v !== p) flips++;
      p = v;
    end
    if (kind == 2) chk(flips >= 3, 1);
    else chk(highs, kind * 20);
    // sync is a 5 high, 5 low square: any 20 cycles hold exactly 10 highs
    if (kind == 2 && sel == 2) chk(highs, 10);
  endtask
  task press;
    @(posedge clk) btn <= 1'b1;
    tick(2);
    btn <= 1'b0;
    tick(4);
    @(negedge clk);
  endtask
  // ==========================================================================
  // scenarios
  task t_reset;
    @(negedge clk);
    chk(duty, 8'h32);
    chk(refsel, 2'h3);
    chk({power_on, white, red}, 3'h0);
    chk({oe1, oe2, oe3}, 24'h0);
    rd(`CSTC_REG_BRIDGE_LO);
    chk(d, 32'h0);
  endtask
  task t_power;
    press;
    chk(power_on, 1'b1);
    watch(0, 1);
    watch(1, 0);
    press;
    chk(power_on, 1'b0);
    watch(0, 0);
  endtask
  task t_lamps;
    press;
    @(posedge clk) intake <= 8'd55;
    watch(0, 1);
    @(posedge clk) intake <= 8'd56;
    watch(0, 2);
    watch(1, 0);
    @(posedge clk) fan_fail <= 1'b1;
    watch(1, 1);
    watch(0, 0);
    @(posedge clk) vfault <= 1'b1;
    watch(1, 2);
    watch(0, 0);
    @(posedge clk) begin
      vfault <= 1'b0; fan_fail <= 1'b0; intake <= 8'd25;
    end
    press;
  endtask
  task t_inhibit;
    @(posedge clk) manual <= 1'b1;
    tick(4);
    @(negedge clk) chk(power_on, 1'b1);
    rd(`CSTC_REG_STATUS);
    chk(d, 32'h33);
    @(posedge clk) pull_low <= 1'b1;
    tick(3);
    @(negedge clk) chk(power_on, 1'b0);
    @(posedge clk) pull_low <= 1'b0;
    tick(4);
    @(negedge clk) chk(power_on, 1'b1);
    @(posedge clk) manual <= 1'b0;
  endtask
  task fan_case(input logic [7:0] s, input logic m, input logic [7:0] e);
    @(posedge clk) begin
      sensor <= s; fan_max <= m;
    end
    tick(3);
    @(negedge clk) chk(duty, e);
  endtask
  task t_fan;
    fan_case(8'd50, 1'b0, 8'h32);
    fan_case(8'd20, 1'b0, `CSTC_FAN_MIN);
    fan_case(8'd120, 1'b0, `CSTC_FAN_FULL);
    fan_case(8'd50, 1'b1, `CSTC_FAN_FULL);
    fan_case(8'd50, 1'b0, 8'h32);
  endtask
  task t_bridge;
    @(posedge clk) begin
      tin1 <= 8'h01; tin2 <= 8'h80; tin3 <= 8'hFF;
    end
    // line 0 forwards up, line 7 forwards down
    wr(`CSTC_REG_BRIDGE_LO, 32'h0000_8001);
    @(negedge clk) chk(bsave, 1'b1);
    @(negedge clk) chk(bsave, 1'b0);
    chk({oe2[0], to2[0], oe1[7], to1[7]}, 4'hF);
    chk({oe1[6:0], oe2[7:1]}, 14'h0040);
    chk({oe3[0], oe3[7]}, 2'h2);
    @(posedge clk) tin1 <= 8'h00;
    tick(2);
    @(negedge clk) chk(to2[0], 1'b0);
    rd(`CSTC_REG_BRIDGE_LO);
    chk(d, 32'h0000_8001);
    rd(8'h3C);
    chk(d, 32'h0);
  endtask
  task ref_case(input logic s, input logic e, input logic [1:0] m);
    @(posedge clk) begin
      slot_ref <= s; ext_ref <= e;
    end
    // the switch waits for the end of a sync period
    tick(14);
    @(negedge clk) chk(refsel, m);
  endtask
  task t_ref;
    ref_case(1'b1, 1'b1, 2'h1);
    ref_case(1'b1, 1'b0, 2'h1);
    ref_case(1'b0, 1'b1, 2'h2);
    ref_case(1'b0, 1'b0, 2'h3);
  endtask
  task t_sync;
    @(posedge clk) sync_ctrl <= 1'b0;
    watch(2, 0);
    @(posedge clk) sync_ctrl <= 1'b1;
    tick(2);
    watch(2, 2);
    wr(`CSTC_REG_CTRL, 32'h1);
    @(posedge clk) sync_ctrl <= 1'b0;
    tick(2);
    watch(2, 2);
    wr(`CSTC_REG_CTRL, 32'h0);
  endtask
  task t_restore;
    @(posedge clk) begin
      saved <= 16'h0002; reset <= 1'b1;
    end
    tick(3);
    reset <= 1'b0;
    tick(3);
    rd(`CSTC_REG_BRIDGE_LO);
    chk(d, 32'h2);
    chk(oe1[0], 1'b1);
  endtask
  // ==========================================================================
  // main sequence and watchdog
  initial begin
    num_errors = 0; n_tests = 0;
    reset = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0;
    ac = 1'b1; btn = 1'b0; manual = 1'b0; pull_low = 1'b0; fan_max = 1'b0;
    fan_fail = 1'b0; vfault = 1'b0; slot_ref = 1'b0; ext_ref = 1'b0;
    sync_ctrl = 1'b0; intake = 8'd25; sensor = 8'd50; saved = 16'h0000;
    tin1 = 8'h00; tin2 = 8'h00; tin3 = 8'h00;
    tick(3);
    reset <= 1'b0;
    tick(2);
    t_reset;
    t_power;
    t_lamps;
    t_inhibit;
    t_fan;
    t_bridge;
    t_ref;
    t_sync;
    t_restore;
    close_out;
  end
  initial begin
    // the scenarios need a few hundred cycles; this is ample margin
    #100000;
    num_errors++;
    close_out;
  end
endmodule // chassis_status_timing_control_tb_top
